/* File: src/dsl_defines.svh */
// timing counts and frame layout for the dual serial load link
`ifndef DSL_DEFINES_SVH
`define DSL_DEFINES_SVH
`define DSL_FRAME_BITS 16
`define DSL_CODE_BITS 14
`define DSL_HALF_CYC 4
`define DSL_LOAD_CYC 2
`define DSL_GAP_CYC 2
`define DSL_FIFO_DEPTH 8
`endif

/* File: src/dsl_pkg.sv */
// types shared by both ends of the dual serial load link
package dsl_pkg;
    typedef logic [15:0] dsl_word_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SHIFT = 5'b00010,
        ST_LOAD = 5'b00100,
        ST_GAP = 5'b01000,
        ST_START = 5'b10000
    } dsl_state_t;
endpackage

/* File: src/dsl_link_if.sv */
// pin-level link between the controller end and the converter end
`timescale 1ns/1ps
interface dsl_link_if;
    logic frame_sync_a_n;
    logic shift_clock_a;
    logic serial_in_a;
    logic load_strobe_a_n;
    logic frame_sync_b_n;
    logic shift_clock_b;
    logic serial_in_b;
    logic load_strobe_b_n;
    modport ctl (
        output frame_sync_a_n, shift_clock_a, serial_in_a, load_strobe_a_n,
        output frame_sync_b_n, shift_clock_b, serial_in_b, load_strobe_b_n
    );
    modport dev (
        input frame_sync_a_n, shift_clock_a, serial_in_a, load_strobe_a_n,
        input frame_sync_b_n, shift_clock_b, serial_in_b, load_strobe_b_n
    );
endinterface

/* File: src/dsl_fifo.sv */
// word buffer with valid and ready on both sides
`timescale 1ns/1ps
module dsl_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // storage, written only on accepted pushes
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // next fill level
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // fill level; ready is kept in a flop so the port has no logic path
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

/* File: src/dsl_dac_end.sv */
// converter end: two serial input latches and two converter latches
//
// What this block does
// - load strobe A fall copies input into converter A
// - strobe A held low: copy on sixteenth fall
// - frame sync A fall starts a channel A frame
// - sample data A on clock falls, sync low
// - load strobe B fall copies input into converter B
// - strobe B held low: copy on sixteenth fall
// - frame sync B fall starts a channel B frame
// - sample data B on clock falls, sync low
// - only converter latch drives the output code
// - converter code is two's complement, 12/14 bits
`timescale 1ns/1ps
`include "dsl_defines.svh"
module dsl_dac_end
    import dsl_pkg::*;
#(
    parameter int CODE_W = `DSL_CODE_BITS
) (
    input wire logic clock,
    input wire logic rst,
    dsl_link_if.dev link,
    output logic signed [CODE_W-1:0] dac_code_a,
    output logic signed [CODE_W-1:0] dac_code_b,
    output logic update_a,
    output logic update_b,
    output logic frame_done_a,
    output logic frame_done_b,
    output logic short_frame_a,
    output logic short_frame_b
);
    localparam int CW = $clog2(`DSL_FRAME_BITS + 1);
    localparam logic [CW-1:0] LAST_BIT = CW'(`DSL_FRAME_BITS - 1);
    localparam logic [CW-1:0] FULL = CW'(`DSL_FRAME_BITS);

    // edge decode shared by the sync, clock and strobe pins
    function automatic logic fell(input logic was, input logic now);
        return was && !now;
    endfunction

    function automatic logic rose(input logic was, input logic now);
        return !was && now;
    endfunction

    // raw pins gathered per channel, index 0 is channel A
    logic [1:0] fs_raw;
    logic [1:0] sck_raw;
    logic [1:0] sd_raw;
    logic [1:0] ld_raw;

    assign fs_raw = {link.frame_sync_b_n, link.frame_sync_a_n};
    assign sck_raw = {link.shift_clock_b, link.shift_clock_a};
    assign sd_raw = {link.serial_in_b, link.serial_in_a};
    assign ld_raw = {link.load_strobe_b_n, link.load_strobe_a_n};

    // two-stage synchronisers; first stage feeds only the second
    logic [1:0] fs_s1;
    logic [1:0] fs_s2;
    logic [1:0] sck_s1;
    logic [1:0] sck_s2;
    logic [1:0] sd_s1;
    logic [1:0] sd_s2;
    logic [1:0] ld_s1;
    logic [1:0] ld_s2;

    // idle levels: syncs and strobes high, clock high
    always_ff @(posedge clock) begin
        if (rst) begin
            fs_s1 <= 2'h3;
            fs_s2 <= 2'h3;
            sck_s1 <= 2'h3;
            sck_s2 <= 2'h3;
            sd_s1 <= 2'h0;
            sd_s2 <= 2'h0;
            ld_s1 <= 2'h3;
            ld_s2 <= 2'h3;
        end else begin
            fs_s1 <= fs_raw;
            fs_s2 <= fs_s1;
            sck_s1 <= sck_raw;
            sck_s2 <= sck_s1;
            sd_s1 <= sd_raw;
            sd_s2 <= sd_s1;
            ld_s1 <= ld_raw;
            ld_s2 <= ld_s1;
        end
    end

    // previous synchronised levels for edge detection
    logic [1:0] fs_d;
    logic [1:0] sck_d;
    logic [1:0] ld_d;

    always_ff @(posedge clock) begin
        if (rst) begin
            fs_d <= 2'h3;
            sck_d <= 2'h3;
            ld_d <= 2'h3;
        end else begin
            fs_d <= fs_s2;
            sck_d <= sck_s2;
            ld_d <= ld_s2;
        end
    end

    // per-channel results, index 0 is channel A
    logic signed [CODE_W-1:0] conv [2];
    logic [1:0] upd;
    logic [1:0] done;
    logic [1:0] short_f;

    // data and clock go through equal sync depth, so the data bit seen
    // with a clock fall is the one the controller set up before it
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic fs_fall;
        logic fs_rise;
        logic sck_fall;
        logic ld_fall;
        logic take_bit;
        logic word_end;
        logic [CW-1:0] bit_count;
        dsl_word_t shifter;
        dsl_word_t in_latch;
        dsl_word_t next_word;

        assign fs_fall = fell(fs_d[ch], fs_s2[ch]);
        assign fs_rise = rose(fs_d[ch], fs_s2[ch]);
        assign sck_fall = fell(sck_d[ch], sck_s2[ch]);
        assign ld_fall = fell(ld_d[ch], ld_s2[ch]);
        // bits count only inside a frame and only up to the word length
        assign take_bit = sck_fall && !fs_s2[ch] && (bit_count != FULL);
        assign word_end = take_bit && (bit_count == LAST_BIT);
        assign next_word = {shifter[14:0], sd_s2[ch]};

        // bit counter restarts at every frame sync fall
        // restart wins over a bit taken in the same cycle
        always_ff @(posedge clock) begin
            if (rst) begin
                bit_count <= '0;
            end else if (fs_fall) begin
                bit_count <= '0;
            end else if (take_bit) begin
                bit_count <= bit_count + 1'b1;
            end
        end

        // msb first shift register
        always_ff @(posedge clock) begin
            if (rst) begin
                shifter <= '0;
            end else if (take_bit) begin
                shifter <= next_word;
            end
        end

        // input latch only takes whole words; a short frame leaves it
        always_ff @(posedge clock) begin
            if (rst) begin
                in_latch <= '0;
            end else if (word_end) begin
                in_latch <= next_word;
            end
        end

        // converter latch: strobe fall, or word end with strobe held low;
        // leading bits above the code width are dropped
        // a strobe fall that meets the 16th bit copies the older word
        always_ff @(posedge clock) begin
            if (rst) begin
                conv[ch] <= '0;
                upd[ch] <= 1'b0;
            end else if (ld_fall) begin
                conv[ch] <= signed'(in_latch[CODE_W-1:0]);
                upd[ch] <= 1'b1;
            end else if (word_end && !ld_s2[ch]) begin
                conv[ch] <= signed'(next_word[CODE_W-1:0]);
                upd[ch] <= 1'b1;
            end else begin
                upd[ch] <= 1'b0;
            end
        end

        // status pulses: word complete, frame closed early
        // short frame: sync rose on a partial word, input latch untouched
        always_ff @(posedge clock) begin
            if (rst) begin
                done[ch] <= 1'b0;
                short_f[ch] <= 1'b0;
            end else begin
                done[ch] <= word_end;
                short_f[ch] <= fs_rise && (bit_count != FULL)
                    && (bit_count != '0);
            end
        end
    end

    // outputs show the converter latch only, never the shifter
    assign dac_code_a = conv[0];
    assign dac_code_b = conv[1];
    assign update_a = upd[0];
    assign update_b = upd[1];
    assign frame_done_a = done[0];
    assign frame_done_b = done[1];
    assign short_frame_a = short_f[0];
    assign short_frame_b = short_f[1];
endmodule

/* File: src/dsl_ctl_end.sv */
// controller end: buffered words shifted out on either channel
`timescale 1ns/1ps
`include "dsl_defines.svh"
module dsl_ctl_end
    import dsl_pkg::*;
#(
    parameter int HALF_CYC = `DSL_HALF_CYC,
    parameter int DEPTH = `DSL_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    dsl_link_if.ctl link,
    input wire logic [15:0] word_data,
    input wire logic word_chan,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic auto_load_a,
    input wire logic auto_load_b,
    output logic busy
);
    localparam int BW = $clog2(`DSL_FRAME_BITS + 1);
    localparam int DW = $clog2(HALF_CYC + 1);

    logic [16:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;
    logic fifo_ready;
    dsl_state_t state;
    logic [DW-1:0] div;
    logic tick;
    logic [BW-1:0] bits_sent;
    logic [3:0] wait_cnt;
    dsl_word_t word;
    logic chan;
    logic [1:0] auto_mode;
    logic [1:0] fs_n;
    logic [1:0] sck;
    logic [1:0] sd;
    logic [1:0] ld_n;

    // the fifo is drained only between frames, so it backs up onto the user
    dsl_fifo #(.WIDTH(17), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data({word_chan, word_data}),
        .in_valid(word_valid),
        .in_ready(fifo_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );
    assign word_ready = fifo_ready;
    assign fifo_take = (state == ST_IDLE);
    assign auto_mode = {auto_load_b, auto_load_a};

    // half-period divider for the shift clock, held in idle
    always_ff @(posedge clock) begin
        if (rst || state == ST_IDLE) begin
            div <= '0;
            tick <= 1'b0;
        end else if (div == DW'(HALF_CYC - 1)) begin
            div <= '0;
            tick <= 1'b1;
        end else begin
            div <= div + 1'b1;
            tick <= 1'b0;
        end
    end

    // frame sequencer: sync fall, data, sixteen clock falls, load strobe unless the channel is in auto mode
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_IDLE;
            word <= '0;
            chan <= 1'b0;
            bits_sent <= '0;
            wait_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        word <= fifo_data[15:0];
                        chan <= fifo_data[16];
                        bits_sent <= '0;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick && sck[chan]) begin
                        bits_sent <= bits_sent + 1'b1;
                    end else if (tick) begin
                        word <= {word[14:0], 1'b0};
                        if (bits_sent == BW'(`DSL_FRAME_BITS)) begin
                            wait_cnt <= '0;
                            state <= auto_mode[chan] ? ST_GAP : ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (tick) begin
                        wait_cnt <= wait_cnt + 1'b1;
                        if (wait_cnt == 4'(`DSL_LOAD_CYC - 1)) begin
                            wait_cnt <= '0;
                            state <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        wait_cnt <= wait_cnt + 1'b1;
                        if (wait_cnt == 4'(`DSL_GAP_CYC - 1)) begin
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // pins: sync low for the frame, data set up while the clock is high
    always_ff @(posedge clock) begin
        if (rst) begin
            fs_n <= 2'h3;
            sck <= 2'h3;
            sd <= 2'h0;
        end else begin
            fs_n <= 2'h3;
            sck <= 2'h3;
            sd <= 2'h0;
            if (state == ST_START) begin
                fs_n[chan] <= 1'b0;
            end else if (state == ST_SHIFT) begin
                fs_n[chan] <= 1'b0;
                sck[chan] <= tick ? !sck[chan] : sck[chan];
                sd[chan] <= word[15];
                if (tick && !sck[chan]
                    && bits_sent == BW'(`DSL_FRAME_BITS)) begin
                    fs_n[chan] <= 1'b1;
                end
            end
        end
    end

    // strobe: held low in auto mode, else one pulse after the frame
    always_ff @(posedge clock) begin
        if (rst) begin
            ld_n <= 2'h3;
        end else begin
            ld_n <= ~auto_mode;
            if (state == ST_LOAD) begin
                ld_n[chan] <= 1'b0;
            end
        end
    end

    // busy whenever a frame or its load is under way
    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != ST_IDLE) || fifo_valid;
        end
    end

    assign link.frame_sync_a_n = fs_n[0];
    assign link.frame_sync_b_n = fs_n[1];
    assign link.shift_clock_a = sck[0];
    assign link.shift_clock_b = sck[1];
    assign link.serial_in_a = sd[0];
    assign link.serial_in_b = sd[1];
    assign link.load_strobe_a_n = ld_n[0];
    assign link.load_strobe_b_n = ld_n[1];
endmodule

/* File: test/dsl_link_props.sv */
// pin-level checks on the link between the controller and converter ends
`timescale 1ns/1ps
module dsl_link_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic frame_sync_a_n,
    input wire logic shift_clock_a,
    input wire logic serial_in_a,
    input wire logic load_strobe_a_n,
    input wire logic frame_sync_b_n,
    input wire logic shift_clock_b,
    input wire logic serial_in_b,
    input wire logic load_strobe_b_n
);
    logic ck_a;
    logic ck_b;
    logic [4:0] nb_a;
    logic [4:0] nb_b;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // previous clock levels, to spot falls
    always_ff @(posedge clock) begin
        ck_a <= shift_clock_a;
        ck_b <= shift_clock_b;
    end
    // falls per frame; cleared while sync is high so each frame starts at 0
    always_ff @(posedge clock) begin
        if (rst || frame_sync_a_n) begin
            nb_a <= 5'h00;
        end else if (ck_a && !shift_clock_a) begin
            nb_a <= nb_a + 5'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (rst || frame_sync_b_n) begin
            nb_b <= 5'h00;
        end else if (ck_b && !shift_clock_b) begin
            nb_b <= nb_b + 5'h01;
        end
    end
    property p_idle_a; frame_sync_a_n |-> shift_clock_a; endproperty
    a_idle_a: assert property (p_idle_a) else $error("clock moves idle");
    property p_hold_a;
        $fell(shift_clock_a) |-> $stable(serial_in_a) ##1 $stable(serial_in_a);
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("data moved");
    property p_start_a;
        $fell(frame_sync_a_n) |-> shift_clock_a [*3];
    endproperty
    a_start_a: assert property (p_start_a) else $error("early fall");
    property p_half_a; $fell(shift_clock_a) |-> !shift_clock_a [*3]; endproperty
    a_half_a: assert property (p_half_a) else $error("short low");
    property p_cnt_a; $rose(frame_sync_a_n) |-> nb_a == 5'h10; endproperty
    a_cnt_a: assert property (p_cnt_a) else $error("bad count a");
    property p_cnt_b; $rose(frame_sync_b_n) |-> nb_b == 5'h10; endproperty
    a_cnt_b: assert property (p_cnt_b) else $error("bad count b");
    property p_frame_a;
        $fell(frame_sync_a_n) |-> ##[120:140] $rose(frame_sync_a_n);
    endproperty
    a_frame_a: assert property (p_frame_a) else $error("frame length");
    property p_strobe_a; $fell(load_strobe_a_n) |-> frame_sync_a_n; endproperty
    a_strobe_a: assert property (p_strobe_a) else $error("strobe in frame");
endmodule

/* File: test/dual_dac_serial_load_interface_tb_top.sv */
// bench joining both link ends, plus a rule-breaking driver on a second link
`timescale 1ns/1ps
module dual_dac_serial_load_interface_tb_top;
    import dsl_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    dsl_word_t word_data = 16'h0000;
    logic word_chan = 1'b0;
    logic word_valid = 1'b0;
    logic auto_load_a = 1'b0;
    logic auto_load_b = 1'b0;
    logic word_ready;
    logic busy;
    logic full_seen;
    logic signed [13:0] code_a;
    logic signed [13:0] code_b;
    logic signed [13:0] f_code;
    logic upd_a;
    logic upd_b;
    logic done_a;
    logic done_b;
    logic f_short;
    int cnt [7] = '{default: 0};
    int failures = 0;
    int checked = 0;
    dsl_link_if i_dsl_link_if ();
    dsl_link_if i_dsl_link_if_f ();
    dsl_ctl_end i_dsl_ctl_end (.clock(clock), .rst(rst),
        .link(i_dsl_link_if), .word_data(word_data), .word_chan(word_chan),
        .word_valid(word_valid), .word_ready(word_ready),
        .auto_load_a(auto_load_a), .auto_load_b(auto_load_b), .busy(busy));
    dsl_dac_end i_dsl_dac_end (.clock(clock), .rst(rst),
        .link(i_dsl_link_if), .dac_code_a(code_a), .dac_code_b(code_b),
        .update_a(upd_a), .update_b(upd_b), .frame_done_a(done_a),
        .frame_done_b(done_b), .short_frame_a(), .short_frame_b());
    // second converter end faces the bench driver, which breaks the rules
    dsl_dac_end i_dsl_dac_end_f (.clock(clock), .rst(rst),
        .link(i_dsl_link_if_f), .dac_code_a(f_code), .dac_code_b(),
        .update_a(), .update_b(), .frame_done_a(), .frame_done_b(),
        .short_frame_a(f_short), .short_frame_b());
    dsl_link_props i_dsl_link_props (.clock(clock), .rst(rst),
        .frame_sync_a_n(i_dsl_link_if.frame_sync_a_n),
        .shift_clock_a(i_dsl_link_if.shift_clock_a),
        .serial_in_a(i_dsl_link_if.serial_in_a),
        .load_strobe_a_n(i_dsl_link_if.load_strobe_a_n),
        .frame_sync_b_n(i_dsl_link_if.frame_sync_b_n),
        .shift_clock_b(i_dsl_link_if.shift_clock_b),
        .serial_in_b(i_dsl_link_if.serial_in_b),
        .load_strobe_b_n(i_dsl_link_if.load_strobe_b_n));
    initial begin
        forever #50 clock = ~clock;
    end
    // pulses are one cycle wide; tallied mid-cycle, where they are settled
    always @(negedge clock) begin
        cnt[0] += (upd_a === 1'b1);
        cnt[1] += (upd_b === 1'b1);
        cnt[2] += (done_a === 1'b1);
        cnt[3] += (done_b === 1'b1);
        cnt[4] += (f_short === 1'b1);
        cnt[5] += ((upd_a & done_a) === 1'b1);
        cnt[6] += ((upd_b & done_b) === 1'b1);
    end
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic wait_for(input int idx, input int target);
        for (int i = 0; i < 3000; i++) begin
            if (cnt[idx] >= target) begin
                return;
            end
            @(negedge clock);
        end
        failures++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        wrap_up();
    endtask
    // valid stays up on return so back-to-back words need no idle cycle
    task automatic send(input logic ch, input dsl_word_t w);
        word_chan = ch;
        word_data = w;
        word_valid = 1'b1;
        for (int i = 0; i < 3000 && word_ready !== 1'b1; i++) begin
            full_seen = 1'b1;
            @(negedge clock);
        end
        chk(word_ready === 1'b1, "word not taken");
        if (word_ready !== 1'b1) begin
            wrap_up();
        end
        @(negedge clock);
    endtask
    task automatic xfer(input logic ch, input dsl_word_t w);
        int d0;
        int u0;
        logic signed [13:0] old;
        d0 = cnt[2 + ch];
        u0 = cnt[ch];
        old = ch ? code_b : code_a;
        send(ch, w);
        word_valid = 1'b0;
        wait_for(2 + ch, d0 + 1);
        chk(busy === 1'b1, "busy low in frame");
        if (cnt[ch] == u0) begin
            chk((ch ? code_b : code_a) === old, "code moved early");
            wait_for(ch, u0 + 1);
        end
        chk((ch ? code_b : code_a) === w[13:0], "code mismatch");
    endtask
    // bench link clock: 4 cycles per half, 800 ns period, with two
    // stray clocks before sync falls that the converter must ignore
    task automatic fsend(input dsl_word_t w, input int n);
        for (int i = -2; i < n; i++) begin
            if (i == 0) begin
                i_dsl_link_if_f.frame_sync_a_n = 1'b0;
                repeat (4) @(negedge clock);
            end
            i_dsl_link_if_f.serial_in_a = (i < 0) ? 1'b1 : w[15 - i];
            repeat (4) @(negedge clock);
            i_dsl_link_if_f.shift_clock_a = 1'b0;
            repeat (4) @(negedge clock);
            i_dsl_link_if_f.shift_clock_a = 1'b1;
        end
        i_dsl_link_if_f.frame_sync_a_n = 1'b1;
        i_dsl_link_if_f.serial_in_a = ~i_dsl_link_if_f.serial_in_a;
        repeat (4) @(negedge clock);
    endtask
    task automatic fstrobe();
        i_dsl_link_if_f.load_strobe_a_n = 1'b0;
        repeat (4) @(negedge clock);
        i_dsl_link_if_f.load_strobe_a_n = 1'b1;
        repeat (8) @(negedge clock);
    endtask
    initial begin
        int n0;
        i_dsl_link_if_f.frame_sync_a_n = 1'b1;
        i_dsl_link_if_f.shift_clock_a = 1'b1;
        i_dsl_link_if_f.serial_in_a = 1'b0;
        i_dsl_link_if_f.load_strobe_a_n = 1'b1;
        i_dsl_link_if_f.frame_sync_b_n = 1'b1;
        i_dsl_link_if_f.shift_clock_b = 1'b1;
        i_dsl_link_if_f.serial_in_b = 1'b0;
        i_dsl_link_if_f.load_strobe_b_n = 1'b1;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        xfer(1'b0, 16'h1234);
        xfer(1'b1, 16'hE001);
        chk(code_b < 0, "code not negative");
        $display("test plain transfers done");
        // strobes held low: the 16th fall itself must load the converter
        auto_load_a = 1'b1;
        auto_load_b = 1'b1;
        repeat (10) @(negedge clock);
        for (int c = 0; c < 2; c++) begin
            n0 = cnt[5 + c];
            xfer(c[0], c ? 16'h1FFF : 16'h2000);
            chk(cnt[5 + c] == n0 + 1, "no load at 16th fall");
        end
        $display("test held strobes done");
        auto_load_a = 1'b0;
        auto_load_b = 1'b0;
        full_seen = 1'b0;
        n0 = cnt[0];
        for (int k = 0; k < 10; k++) begin
            send(1'b0, {12'h010, k[3:0]});
        end
        word_valid = 1'b0;
        chk(full_seen === 1'b1, "buffer never refused");
        wait_for(0, n0 + 10);
        chk(code_a === 14'h0109, "last word lost");
        $display("test buffer fill done");
        fsend(16'h0ABC, 16);
        fstrobe();
        chk(f_code === 14'h0ABC, "load on faulty link");
        fsend(16'h1555, 5);
        fstrobe();
        chk(cnt[4] == 1 && f_code === 14'h0ABC, "short frame");
        fsend(16'h2345, 16);
        fstrobe();
        chk(f_code === 14'h2345, "frame restart");
        chk(busy === 1'b0 && word_ready === 1'b1, "ctl not idle");
        $display("test faulty controller done");
        wrap_up();
    end
endmodule
